// [design/pd_regs_pkg.sv]
package pd_regs_pkg;
   // register offsets on the register port
   localparam logic [7:0] FAULT_CTRL_ADDR = 8'h1B;
   localparam logic [7:0] POWER_CTRL_ADDR = 8'h1C;
   // reset values
   localparam logic [7:0] FAULT_CTRL_RESET = 8'h00;
   localparam logic [7:0] POWER_CTRL_RESET = 8'h60;
   // writable bit masks; reserved bits read zero
   localparam logic [7:0] FAULT_CTRL_WMASK = 8'h0F;
   localparam logic [7:0] POWER_CTRL_WMASK = 8'h77;
   // fault control field positions
   localparam int FC_VCONN_OC  = 0;
   localparam int FC_BUS_OV    = 1;
   localparam int FC_BUS_OC    = 2;
   localparam int FC_DIS_TMR   = 3;
   // power control field positions
   localparam int PC_VCONN_EN  = 0;
   localparam int PC_LVL_HINT  = 1;
   localparam int PC_FORCE_DR  = 2;
   localparam int PC_UNPLUG_DR = 4;
   localparam int PC_ALARM_DIS = 5;
   localparam int PC_ADC_DIS   = 6;
   // cc line state encoding
   localparam logic [1:0] CC_OPEN = 2'h0;
endpackage

// [design/pd_fault_power_control_regs.sv]
module pd_fault_power_control_regs
   import pd_regs_pkg::*;
(
   input  wire logic       clk_i,               // system clock
   input  wire logic       rstn_i,              // async reset, active low
   input  wire logic       wr_i,                // register write strobe
   input  wire logic       rd_i,                // register read strobe
   input  wire logic [7:0] addr_i,              // register offset
   input  wire logic [7:0] wdata_i,             // write data
   input  wire logic       plug_side_select_i,  // orientation bit from control register
   input  wire logic [1:0] cc1_state_i,         // raw cc1 line state (pin domain)
   input  wire logic [1:0] cc2_state_i,         // raw cc2 line state (pin domain)
   input  wire logic       shield_fault_protection_i, // shield protection active (pin)
   input  wire logic       fault_action_a_i,    // fault class A in effect
   input  wire logic       bus_oc_raw_i,        // raw bus overcurrent comparator
   input  wire logic       bus_ov_raw_i,        // raw bus overvoltage comparator
   input  wire logic       vconn_oc_raw_i,      // raw cable power overcurrent
   output logic [7:0]      rdata_o,             // read data
   output logic [1:0]      cc1_line_state_o,    // reported cc1 state
   output logic [1:0]      cc2_line_state_o,    // reported cc2 state
   output logic            vconn_cc1_o,         // cable power switch on cc1
   output logic            vconn_cc2_o,         // cable power switch on cc2
   output logic            bus_source_en_o,     // bus sourcing allowed
   output logic            bus_discharge_o,     // bus discharge switch
   output logic            adc_enable_o,        // bus adc monitor running
   output logic            alarm_enable_o,      // voltage alarm reporting on
   output logic            discharge_timer_en_o, // discharge failure timers run
   output logic            bus_oc_fault_o,      // qualified bus overcurrent
   output logic            bus_ov_fault_o,      // qualified bus overvoltage
   output logic            vconn_oc_fault_o     // qualified cable overcurrent
);
   logic [7:0] fault_detect_control;  // fault control register
   logic [7:0] power_path_control;    // power control register
   logic [7:0] pend_data;             // write parked during fault action A
   logic       pend_valid;            // parked write waiting
   logic [4:0] sync1;                 // first synchroniser stage
   logic [4:0] sync2;                 // second synchroniser stage
   logic [1:0] cc1_s;                 // synchronised cc1
   logic [1:0] cc2_s;                 // synchronised cc2
   logic       shield_s;              // synchronised shield protection
   logic       unplug;                // orientation-selected cc reads open
   logic       wr_fc;                 // write hits fault control
   logic       wr_pc;                 // write hits power control

   assign wr_fc = wr_i && (addr_i == FAULT_CTRL_ADDR);
   assign wr_pc = wr_i && (addr_i == POWER_CTRL_ADDR);

   // two-flop synchroniser for pin-domain inputs
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end else begin
         sync1 <= {shield_fault_protection_i, cc2_state_i, cc1_state_i};
         sync2 <= sync1;
      end
   end
   assign cc1_s    = sync2[1:0];
   assign cc2_s    = sync2[3:2];
   assign shield_s = sync2[4];

   // orientation selects the vconn pin: 1 means cc1, so sense cc2 for the partner
   // disconnect seen on the line that is not carrying vconn
   assign unplug = plug_side_select_i ? (cc2_s == CC_OPEN) : (cc1_s == CC_OPEN);

   // fault control register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_detect_control <= FAULT_CTRL_RESET;
      // only a port manager write changes it
      end else if (wr_fc) begin
         fault_detect_control <= wdata_i & FAULT_CTRL_WMASK;
      end
   end

   // parked power control write, replayed when fault A clears
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_valid <= 1'b0;
         pend_data  <= 8'h00;
      // capture the write while blocked, newest wins
      end else if (wr_pc && fault_action_a_i) begin
         pend_valid <= 1'b1;
         pend_data  <= wdata_i;
      end else if (!fault_action_a_i) begin
         pend_valid <= 1'b0;
      end
   end

   // power control register; shield clear wins over any write
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         power_path_control <= POWER_CTRL_RESET;
      end else begin
         if (!fault_action_a_i && wr_pc) begin
            power_path_control <= wdata_i & POWER_CTRL_WMASK;
         // apply deferred write once fault cleared
         end else if (!fault_action_a_i && pend_valid) begin
            power_path_control <= pend_data & POWER_CTRL_WMASK;
         end
         if (shield_s) begin
            power_path_control[PC_VCONN_EN] <= 1'b0;
         end
      end
   end

   // read mux; reserved bits already zero in storage
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i && addr_i == FAULT_CTRL_ADDR) begin
         rdata_o <= fault_detect_control;
      end else if (rd_i && addr_i == POWER_CTRL_ADDR) begin
         rdata_o <= power_path_control;
      end else if (rd_i) begin
         rdata_o <= 8'h00;
      end
   end

   // power path outputs; the level hint bit drives nothing
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         vconn_cc1_o     <= 1'b0;
         vconn_cc2_o     <= 1'b0;
         bus_source_en_o <= 1'b1;
         bus_discharge_o <= 1'b0;
         adc_enable_o    <= 1'b0;
         alarm_enable_o  <= 1'b0;
      end else begin
         // vconn follows only the enable and orientation
         vconn_cc1_o <= power_path_control[PC_VCONN_EN] && plug_side_select_i;
         vconn_cc2_o <= power_path_control[PC_VCONN_EN] && !plug_side_select_i;
         // sourcing stops first; discharge follows a cycle later
         bus_source_en_o <= !(power_path_control[PC_UNPLUG_DR] && unplug);
         bus_discharge_o <= power_path_control[PC_FORCE_DR] ||
                            (power_path_control[PC_UNPLUG_DR] && unplug && !bus_source_en_o);
         adc_enable_o <= !power_path_control[PC_ADC_DIS];
         alarm_enable_o <= !power_path_control[PC_ALARM_DIS];
      end
   end

   // cc state report, vconn line forced open
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cc1_line_state_o <= CC_OPEN;
         cc2_line_state_o <= CC_OPEN;
      end else begin
         // the pin carrying vconn reads open
         cc1_line_state_o <= (power_path_control[PC_VCONN_EN] && plug_side_select_i) ? CC_OPEN : cc1_s;
         cc2_line_state_o <= (power_path_control[PC_VCONN_EN] && !plug_side_select_i) ? CC_OPEN : cc2_s;
      end
   end

   // fault qualification; raw comparators are on this clock
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bus_oc_fault_o       <= 1'b0;
         bus_ov_fault_o       <= 1'b0;
         vconn_oc_fault_o     <= 1'b0;
         discharge_timer_en_o <= 1'b1;
      end else begin
         // a set disable bit masks the fault
         bus_oc_fault_o   <= bus_oc_raw_i && !fault_detect_control[FC_BUS_OC];
         bus_ov_fault_o   <= bus_ov_raw_i && !fault_detect_control[FC_BUS_OV];
         vconn_oc_fault_o <= vconn_oc_raw_i && !fault_detect_control[FC_VCONN_OC];
         // timer enable is active low in the register
         discharge_timer_en_o <= !fault_detect_control[FC_DIS_TMR];
      end
   end

   // checks
   AST_FC_RESERVED: assert property (@(posedge clk_i) disable iff (!rstn_i)
      fault_detect_control[7:4] == 4'h0) else $error("fault reserved bits set");
   AST_PC_RESERVED: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[7] == 1'b0 && power_path_control[3] == 1'b0) else $error("power reserved bits set");
   AST_FC_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !wr_fc |=> $stable(fault_detect_control)) else $error("fault control changed without write");
   AST_BLOCK_A: assert property (@(posedge clk_i) disable iff (!rstn_i)
      fault_action_a_i && !shield_s |=> $stable(power_path_control)) else $error("write during fault A");
   sequence s_blocked_write;
      wr_pc && fault_action_a_i ##1 !fault_action_a_i && !wr_pc && !shield_s;
   endsequence
   AST_REPLAY: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_blocked_write |=> power_path_control == (pend_data & POWER_CTRL_WMASK)) else $error("deferred write lost");
   AST_SHIELD: assert property (@(posedge clk_i) disable iff (!rstn_i)
      shield_s |=> !power_path_control[PC_VCONN_EN]) else $error("vconn kept under shield");
   AST_OC_MASK: assert property (@(posedge clk_i) disable iff (!rstn_i)
      bus_oc_raw_i && fault_detect_control[FC_BUS_OC] |=> !bus_oc_fault_o) else $error("masked oc flagged");
   AST_ADC: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ##1 adc_enable_o == !$past(power_path_control[PC_ADC_DIS])) else $error("adc enable wrong");
   AST_VCONN_OPEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[PC_VCONN_EN] && plug_side_select_i |=> cc1_line_state_o == CC_OPEN)
      else $error("vconn pin not open");
   AST_UNPLUG: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(bus_discharge_o) && !$past(power_path_control[PC_FORCE_DR]) |-> !$past(bus_source_en_o))
      else $error("discharge before source off");

   AST_OV_MASK: assert property (@(posedge clk_i) disable iff (!rstn_i)
      bus_ov_raw_i && fault_detect_control[FC_BUS_OV] |=> !bus_ov_fault_o)
      else $error("masked ov flagged");
   AST_VOC_MASK: assert property (@(posedge clk_i) disable iff (!rstn_i)
      vconn_oc_raw_i && fault_detect_control[FC_VCONN_OC] |=> !vconn_oc_fault_o)
      else $error("masked cable oc flagged");

   AST_OC_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      bus_oc_raw_i && !fault_detect_control[FC_BUS_OC] |=> bus_oc_fault_o)
      else $error("enabled oc lost");
   AST_OV_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      bus_ov_raw_i && !fault_detect_control[FC_BUS_OV] |=> bus_ov_fault_o)
      else $error("enabled ov lost");
   AST_VOC_PASS: assert property (@(posedge clk_i) disable iff (!rstn_i)
      vconn_oc_raw_i && !fault_detect_control[FC_VCONN_OC] |=> vconn_oc_fault_o)
      else $error("enabled cable oc lost");

   AST_TMR_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
      fault_detect_control[FC_DIS_TMR] |=> !discharge_timer_en_o)
      else $error("timer runs while disabled");
   AST_TMR_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !fault_detect_control[FC_DIS_TMR] |=> discharge_timer_en_o)
      else $error("timer stopped while enabled");

   AST_ALARM_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[PC_ALARM_DIS] |=> !alarm_enable_o)
      else $error("alarm on while disabled");
   AST_ALARM_ON: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !power_path_control[PC_ALARM_DIS] |=> alarm_enable_o)
      else $error("alarm off while enabled");

   AST_FC_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_fc |=> fault_detect_control == ($past(wdata_i) & FAULT_CTRL_WMASK))
      else $error("fault control write lost");
   AST_PC_WRITE: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_pc && !fault_action_a_i && !shield_s |=> power_path_control == ($past(wdata_i) & POWER_CTRL_WMASK))
      else $error("power control write lost");
   AST_PC_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !wr_pc && !pend_valid && !shield_s |=> $stable(power_path_control))
      else $error("power control changed without write");

   AST_VCONN_KEEP: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[PC_VCONN_EN] && !wr_pc && !pend_valid && !shield_s
      |=> power_path_control[PC_VCONN_EN])
      else $error("vconn enable dropped by itself");
   AST_VCONN_CC1: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[PC_VCONN_EN] && plug_side_select_i |=> vconn_cc1_o && !vconn_cc2_o)
      else $error("vconn not on cc1");
   AST_VCONN_CC2: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[PC_VCONN_EN] && !plug_side_select_i |=> vconn_cc2_o && !vconn_cc1_o)
      else $error("vconn not on cc2");
   AST_VCONN_OPEN2: assert property (@(posedge clk_i) disable iff (!rstn_i)
      power_path_control[PC_VCONN_EN] && !plug_side_select_i |=> cc2_line_state_o == CC_OPEN)
      else $error("vconn pin cc2 not open");

   AST_HINT_INERT: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $changed(power_path_control[PC_LVL_HINT]) && $stable(power_path_control[PC_VCONN_EN]) &&
      $stable(plug_side_select_i) |=> $stable(vconn_cc1_o) && $stable(vconn_cc2_o))
      else $error("level hint moved vconn");

   AST_RD_FC_RES: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == FAULT_CTRL_ADDR |=> rdata_o[7:4] == 4'h0)
      else $error("fault reserved bits read set");
   AST_RD_PC_RES: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == POWER_CTRL_ADDR |=> rdata_o[7] == 1'h0 && rdata_o[3] == 1'h0)
      else $error("power reserved bits read set");

   // unplug steps: sourcing stops, then the drain starts
   sequence s_unplug_seen;
      power_path_control[PC_UNPLUG_DR] && unplug;
   endsequence
   sequence s_source_dropped;
      power_path_control[PC_UNPLUG_DR] && unplug && !bus_source_en_o;
   endsequence
   AST_SOURCE_OFF: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_unplug_seen |=> !bus_source_en_o)
      else $error("sourcing kept after unplug");
   AST_DRAIN_AFTER: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s_source_dropped |=> bus_discharge_o)
      else $error("no drain after source off");
endmodule

// [dv/pm_model.sv]
// port manager on the register port; drives at the falling edge
module pm_model
   import pd_regs_pkg::*;
(
   input  wire logic       clk_i,   // system clock
   output logic            wr_o,    // write strobe
   output logic            rd_o,    // read strobe
   output logic [7:0]      addr_o,  // register offset
   output logic [7:0]      wdata_o, // write data
   output logic            plug_o   // orientation level
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      wr_o = 0; rd_o = 0; addr_o = 8'h00; wdata_o = 8'h00; plug_o = 0;
   end
   // one-cycle write; data inverted afterwards so stale bytes never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i); wr_o = 1; addr_o = a; wdata_o = d;
      @(negedge clk_i); wr_o = 0; wdata_o = ~d;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk_i); rd_o = 1; addr_o = a;
      @(negedge clk_i); rd_o = 0; addr_o = ~a;
   endtask
   task automatic power_on(input logic side, input logic [7:0] d);
      plug_o = side;
      wr(POWER_CTRL_ADDR, d);
   endtask
   // cable power stop by writing the reset value
   task automatic cable_off();
      wr(POWER_CTRL_ADDR, POWER_CTRL_RESET);
   endtask
endmodule

// [dv/tb.sv]
module tb;
   import pd_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rstn_i = 0, wr, rd, plug, shield = 0, fa = 0, oc = 0, ov = 0, voc = 0;
   logic [7:0] addr, wdata, rdata_o, r;
   logic [1:0] cc1 = 2'h2, cc2 = 2'h2, c1_o, c2_o;
   logic v1, v2, src, dis, adc, alm, tmr, f_oc, f_ov, f_voc;
   int errors = 0, check_count = 0;
   logic [7:0] q[$];    // expected read data, oldest first
   pm_model pm_model_i (.clk_i(clk_i), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata), .plug_o(plug));
   pd_fault_power_control_regs pd_fault_power_control_regs_i (.clk_i(clk_i), .rstn_i(rstn_i), .wr_i(wr),
      .rd_i(rd), .addr_i(addr), .wdata_i(wdata), .plug_side_select_i(plug), .cc1_state_i(cc1),
      .cc2_state_i(cc2), .shield_fault_protection_i(shield), .fault_action_a_i(fa), .bus_oc_raw_i(oc),
      .bus_ov_raw_i(ov), .vconn_oc_raw_i(voc), .rdata_o(rdata_o), .cc1_line_state_o(c1_o),
      .cc2_line_state_o(c2_o), .vconn_cc1_o(v1), .vconn_cc2_o(v2), .bus_source_en_o(src),
      .bus_discharge_o(dis), .adc_enable_o(adc), .alarm_enable_o(alm), .discharge_timer_en_o(tmr),
      .bus_oc_fault_o(f_oc), .bus_ov_fault_o(f_ov), .vconn_oc_fault_o(f_voc));
   initial forever #2.5 clk_i = ~clk_i;
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic chk_pin(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp(n, e, s);
   endtask
   // read data lands on the rising edge that samples the strobe; checked at the next falling edge
   always @(posedge clk_i) begin
      if (rd === 1'b1) begin
         @(negedge clk_i);
         cmp("rdata", q.pop_front(), rdata_o);
      end
   end
   task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
      q.push_back(e);
      pm_model_i.rd(a);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // about 130 cycles are expected; far beyond that means a hang
   initial begin
      #100us;
      errors++;
      close_out();
   end
   initial begin
      void'($urandom(54676));
      cyc(12);
      rstn_i = 1;
      rd_exp(FAULT_CTRL_ADDR, 8'h00);
      rd_exp(POWER_CTRL_ADDR, 8'h60);
      chk_pin("adc", 0, adc);
      chk_pin("alarm", 0, alm);
      chk_pin("timer", 1, tmr);
      $display("test reset done");
      // random fault masks against random raw faults
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         {oc, ov, voc} = r[7:5];
         pm_model_i.wr(FAULT_CTRL_ADDR, r);
         cyc(2);
         chk_pin("faults", {5'h00, r[7:5] & ~r[2:0]}, {5'h00, f_oc, f_ov, f_voc});
         chk_pin("timer", {7'h00, ~r[3]}, {7'h00, tmr});
         rd_exp(FAULT_CTRL_ADDR, r & 8'h0F);
      end
      pm_model_i.wr(8'h1D, 8'hFF);
      rd_exp(8'h1D, 8'h00);
      rd_exp(FAULT_CTRL_ADDR, r & 8'h0F);
      $display("test fault control done");
      pm_model_i.wr(POWER_CTRL_ADDR, 8'h8A);
      cyc(2);
      rd_exp(POWER_CTRL_ADDR, 8'h02);
      chk_pin("adc", 1, adc);
      chk_pin("alarm", 1, alm);
      chk_pin("vconn", 0, {v1, v2});
      fa = 1;
      pm_model_i.wr(POWER_CTRL_ADDR, 8'h64);
      cyc(2);
      rd_exp(POWER_CTRL_ADDR, 8'h02);
      chk_pin("discharge", 0, dis);
      fa = 0;
      cyc(3);
      rd_exp(POWER_CTRL_ADDR, 8'h64);
      chk_pin("discharge", 1, dis);
      $display("test power control done");
      pm_model_i.power_on(1, 8'h61);
      cyc(4);
      chk_pin("vconn", 2'h2, {v1, v2});
      chk_pin("cc1 state", 2'h0, c1_o);
      cc1 = 2'h1;
      cc2 = 2'h0;
      cyc(5);
      chk_pin("vconn", 2'h2, {v1, v2});
      shield = 1;
      cyc(5);
      chk_pin("vconn", 2'h0, {v1, v2});
      rd_exp(POWER_CTRL_ADDR, 8'h60);
      shield = 0;
      cc2 = 2'h2;
      // shield must leave both synchroniser stages, or it clears the new enable
      cyc(3);
      pm_model_i.power_on(0, 8'h61);
      cyc(2);
      chk_pin("vconn", 2'h1, {v1, v2});
      chk_pin("cc2 state", 2'h0, c2_o);
      chk_pin("cc1 state", 2'h1, c1_o);
      pm_model_i.cable_off();
      cyc(2);
      chk_pin("vconn", 2'h0, {v1, v2});
      $display("test cable power done");
      pm_model_i.power_on(1, 8'h70);
      cyc(5);
      chk_pin("source", 1, src);
      cc2 = 2'h0;
      for (int i = 0; i < 20 && src !== 1'b0; i++) cyc(1);
      chk_pin("source", 0, src);
      chk_pin("discharge", 0, dis);
      cyc(1);
      chk_pin("discharge", 1, dis);
      cyc(3);
      $display("test unplug done");
      close_out();
   end
endmodule
